// [common/synth_regs_pkg.sv]
// package: register map, field layout, resets and serial framing for the synth control bank
package synth_regs_pkg;

  // register addresses (six-bit serial address)
  localparam logic [5:0] ADDR_ID_STROBE = 6'h00;
  localparam logic [5:0] ADDR_ENABLES = 6'h01;
  localparam logic [5:0] ADDR_DRV_FORCE = 6'h02;
  localparam logic [5:0] ADDR_REFPATH = 6'h03;
  localparam logic [5:0] ADDR_PRESC = 6'h04;
  localparam logic [5:0] ADDR_PFD = 6'h05;
  localparam logic [5:0] ADDR_PFD_DELAY = 6'h06;

  // strobe bit positions
  localparam int STB_REGS_RST = 0;
  localparam int STB_DIG_RST = 1;
  localparam int STB_TEMP = 3;

  // enable register bit positions
  localparam int EN_BIAS = 1;
  localparam int EN_REFDIV = 2;
  localparam int EN_MOD_CLK_SEL = 9;
  localparam int EN_PUMP = 12;
  localparam int EN_MOD_RSTN = 13;
  localparam int EN_LOCK_RSTN = 14;
  localparam int EN_LOCK_GATE = 11;
  localparam int EN_SLIP_RSTN = 15;

  // driver force, reference path, detector field positions
  localparam int DRV_FORCE_VAL = 0;
  localparam int DRV_FORCE_EN = 1;
  localparam int REF_RATIO_MSB = 13;
  localparam int REF_DIV_SEL = 14;
  localparam int REF_AUTO_SEL = 15;
  localparam int REF_SINE_SEL = 16;
  localparam int PFD_POLARITY = 0;
  localparam int PFD_UP_EN = 1;
  localparam int PFD_DN_EN = 2;

  // widths and reset values
  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;
  localparam int FRAME_BITS = 31;
  localparam logic [15:0] RST_ENABLES = 16'hFE9B;
  localparam logic [1:0] RST_DRV_FORCE = 2'h3;
  localparam logic [16:0] RST_REFPATH = 17'h08001;
  localparam logic RST_PRESC = 1'h0;
  localparam logic [2:0] RST_PFD = 3'h6;
  localparam logic [2:0] RST_PFD_DELAY = 3'h2;

  // decoded control levels toward the analog and digital blocks
  typedef struct packed {
    logic loop_enable;
    logic refdiv_active;
    logic [13:0] refdiv_ratio;
    logic sine_ref_sel;
    logic mod_clk_from_vco;
    logic pump_enable;
    logic mod_run;
    logic lock_run;
    logic lock_gate;
    logic slip_prevent_en;
    logic presc_long_low;
    logic pfd_invert;
    logic pfd_up_en;
    logic pfd_dn_en;
    logic [2:0] pfd_delay;
  } synth_ctrl_t;

endpackage : synth_regs_pkg

// [hdl/synth_enable_refpath_pfd_regs.sv]
// serial-port control register bank, addresses 00h through 06h
// Overview of operation
// - address zero reads a fixed 24-bit identification word; writes never change it
// - strobe bit 0 written one restores every configuration register default
// - strobe bit 1 written one resets the remaining digital logic
// - strobe bit 3 written one clocks one temperature conversion
// - bias enable bit 1 zero disables the whole loop
// - reference divider enable bit 2 zero holds divider in reset, like bypass
// - enable bit 9 picks modulator clock: one vco feedback, zero reference
// - pump enable bit 12 cleared puts the pump output high impedance
// - bit 13 low holds the fractional modulator in reset
// - bit 14 low resets lock detect; bit 11 gates lock outputs
// - bit 15 releases detector flip-flops for cycle slip prevention
// - force enable one makes pin driver follow force value bit
// - force enable zero drives pin only during a serial read
// - 14-bit ratio divides crystal when divider enabled and selected; zero illegal
// - reference bit 14 one selects divider, zero bypasses; ignored while auto bit 15 is set
// - auto bit 15 bypasses divider when ratio equals one
// - duty mode bit lengthens divider low time from 15 to 47 cycles
// - polarity bit inverts phase detector polarity
// - detector bits 1 and 2 mask up and down outputs
// - three-bit delay setpoint, default two
// - frame: read flag, six address bits, 24 data bits, msb first
`timescale 1ns/1ps
`default_nettype none

module synth_enable_refpath_pfd_regs
  import synth_regs_pkg::*;
#(
  parameter logic [23:0] ID_WORD = 24'hA5C3E1 // arbitrary identification value
) (
  // system
  input wire logic i_clk,
  input wire logic i_reset_n,
  // four-wire serial port pins
  input wire logic i_sclk,
  input wire logic i_sen,
  input wire logic i_sdi,
  // shared lock detect / serial out pin
  input wire logic i_lock_status,
  output logic o_lock_or_serial_out_pin,
  output logic o_lock_or_serial_out_pin_oe,
  // strobes and decoded controls
  output logic o_digital_reset,
  output logic o_temp_clock,
  output synth_ctrl_t o_ctrl
);

  // three-stage pin synchronisers; stage 1 feeds only stage 2
  logic [2:0] sclk_sync_q;
  logic [2:0] sen_sync_q;
  logic [2:0] sdi_sync_q;
  logic sclk_lvl_q;
  logic sen_lvl_q;

  // serial clock pin synchroniser
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_sync_q <= 3'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
    end
  end

  // frame enable pin synchroniser
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sen_sync_q <= 3'h0;
    end else begin
      sen_sync_q <= {sen_sync_q[1:0], i_sen};
    end
  end

  // serial data pin synchroniser; same depth as the clock so bits stay aligned
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sdi_sync_q <= 3'h0;
    end else begin
      sdi_sync_q <= {sdi_sync_q[1:0], i_sdi};
    end
  end

  // debounced serial clock: changes only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_lvl_q <= 1'h0;
    end else if (sclk_sync_q[1] == sclk_sync_q[2]) begin
      sclk_lvl_q <= sclk_sync_q[2];
    end
  end

  // debounced frame enable; a one-cycle glitch on the pin never opens a frame
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sen_lvl_q <= 1'h0;
    end else if (sen_sync_q[1] == sen_sync_q[2]) begin
      sen_lvl_q <= sen_sync_q[2];
    end
  end

  // edge and level qualifiers; reset level matches the idle low pin, so no false edge
  logic sclk_rise;
  logic sen_active;
  assign sclk_rise = (sclk_sync_q[1] == sclk_sync_q[2]) && sclk_sync_q[2] && !sclk_lvl_q;
  assign sen_active = sen_lvl_q;

  // frame shifter
  logic [5:0] bit_cnt_q;
  logic is_read_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] rd_data_q;
  logic wr_commit;
  logic [DATA_W-1:0] wr_data;
  assign wr_data = {shift_q[DATA_W-2:0], sdi_sync_q[2]};

  // a serial bit is taken on each qualified rising edge inside a frame
  logic take_bit;
  assign take_bit = sen_active && sclk_rise;

  // bit counter; stops at the frame length so stray edges cannot wrap it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_q <= 6'h00;
    end else if (!sen_active) begin
      bit_cnt_q <= 6'h00;
    end else if (sclk_rise && bit_cnt_q < 6'(FRAME_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // first bit is the read flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      is_read_q <= 1'h0;
    end else if (!sen_active) begin
      is_read_q <= 1'h0;
    end else if (sclk_rise && bit_cnt_q == 6'h00) begin
      is_read_q <= sdi_sync_q[2];
    end
  end

  // six address bits, msb first; kept after the frame for the read mux
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_q <= 6'h00;
    end else if (take_bit && bit_cnt_q != 6'h00 && bit_cnt_q <= 6'(ADDR_W)) begin
      addr_q <= {addr_q[ADDR_W-2:0], sdi_sync_q[2]};
    end
  end

  // remaining 24 bits are data, msb first
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_q <= 24'h000000;
    end else if (take_bit && bit_cnt_q > 6'(ADDR_W) && bit_cnt_q < 6'(FRAME_BITS)) begin
      shift_q <= wr_data;
    end
  end

  // the 31st rising edge (count 30) carries the last data bit and commits the word
  assign wr_commit = take_bit && !is_read_q && bit_cnt_q == 6'(FRAME_BITS - 1);

  // configuration registers
  logic [15:0] enables_q;
  logic [1:0] drv_force_q;
  logic [16:0] refpath_q;
  logic presc_q;
  logic [2:0] pfd_q;
  logic [2:0] pfd_delay_q;
  logic regs_soft_rst;

  // one write select per address; address zero only strobes, unmapped ones store nothing
  logic wr_strobe;
  logic wr_enables;
  logic wr_drv_force;
  logic wr_refpath;
  logic wr_presc;
  logic wr_pfd;
  logic wr_pfd_delay;
  assign wr_strobe = wr_commit && addr_q == ADDR_ID_STROBE;
  assign wr_enables = wr_commit && addr_q == ADDR_ENABLES;
  assign wr_drv_force = wr_commit && addr_q == ADDR_DRV_FORCE;
  assign wr_refpath = wr_commit && addr_q == ADDR_REFPATH;
  assign wr_presc = wr_commit && addr_q == ADDR_PRESC;
  assign wr_pfd = wr_commit && addr_q == ADDR_PFD;
  assign wr_pfd_delay = wr_commit && addr_q == ADDR_PFD_DELAY;

  assign regs_soft_rst = wr_strobe && wr_data[STB_REGS_RST];

  // enable and reset register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enables_q <= RST_ENABLES;
    end else if (regs_soft_rst) begin
      enables_q <= RST_ENABLES;
    end else if (wr_enables) begin
      enables_q <= wr_data[15:0];
    end
  end

  // pin driver force register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drv_force_q <= RST_DRV_FORCE;
    end else if (regs_soft_rst) begin
      drv_force_q <= RST_DRV_FORCE;
    end else if (wr_drv_force) begin
      drv_force_q <= wr_data[1:0];
    end
  end

  // reference path register; a zero ratio is stored as written
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refpath_q <= RST_REFPATH;
    end else if (regs_soft_rst) begin
      refpath_q <= RST_REFPATH;
    end else if (wr_refpath) begin
      refpath_q <= wr_data[16:0];
    end
  end

  // prescaler duty mode register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      presc_q <= RST_PRESC;
    end else if (regs_soft_rst) begin
      presc_q <= RST_PRESC;
    end else if (wr_presc) begin
      presc_q <= wr_data[0];
    end
  end

  // phase detector polarity and mask register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pfd_q <= RST_PFD;
    end else if (regs_soft_rst) begin
      pfd_q <= RST_PFD;
    end else if (wr_pfd) begin
      pfd_q <= wr_data[2:0];
    end
  end

  // phase detector delay register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pfd_delay_q <= RST_PFD_DELAY;
    end else if (regs_soft_rst) begin
      pfd_delay_q <= RST_PFD_DELAY;
    end else if (wr_pfd_delay) begin
      pfd_delay_q <= wr_data[2:0];
    end
  end

  // digital reset pulse, one cycle per write of a one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_digital_reset <= 1'h0;
    end else begin
      o_digital_reset <= wr_strobe && wr_data[STB_DIG_RST];
    end
  end

  // temperature clock pulse; recomputed each cycle so nothing lingers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_temp_clock <= 1'h0;
    end else begin
      o_temp_clock <= wr_strobe && wr_data[STB_TEMP];
    end
  end

  // read mux; unmapped addresses read zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = 24'h000000;
    unique case (addr_q)
      ADDR_ID_STROBE: rd_mux = ID_WORD;
      ADDR_ENABLES: rd_mux = {8'h00, enables_q};
      ADDR_DRV_FORCE: rd_mux = {22'h000000, drv_force_q};
      ADDR_REFPATH: rd_mux = {7'h00, refpath_q};
      ADDR_PRESC: rd_mux = {23'h000000, presc_q};
      ADDR_PFD: rd_mux = {21'h000000, pfd_q};
      ADDR_PFD_DELAY: rd_mux = {21'h000000, pfd_delay_q};
      default: rd_mux = 24'h000000;
    endcase
  end

  // read data launched after the last address bit, shifted on rising edges
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_data_q <= 24'h000000;
    end else if (sen_active && is_read_q && sclk_rise) begin
      if (bit_cnt_q == 6'(ADDR_W + 1)) rd_data_q <= rd_mux;
      else rd_data_q <= {rd_data_q[DATA_W-2:0], 1'h0};
    end
  end

  // pin data and driver enable; lock status shows outside reads
  logic read_active;
  assign read_active = sen_active && is_read_q && bit_cnt_q > 6'(ADDR_W);

  // pin data: read bit while reading, lock status otherwise
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lock_or_serial_out_pin <= 1'h0;
    end else begin
      o_lock_or_serial_out_pin <= read_active ? rd_data_q[DATA_W-1] : i_lock_status;
    end
  end

  // pin driver enable; forcing it off also blocks reads, the host then sees a floating line
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lock_or_serial_out_pin_oe <= 1'h0;
    end else if (drv_force_q[DRV_FORCE_EN]) begin
      o_lock_or_serial_out_pin_oe <= drv_force_q[DRV_FORCE_VAL];
    end else begin
      o_lock_or_serial_out_pin_oe <= read_active;
    end
  end

  // decoded controls, next value; every field is written so nothing latches
  synth_ctrl_t ctrl_d;
  always_comb begin
    ctrl_d.loop_enable = enables_q[EN_BIAS];
    ctrl_d.refdiv_active = enables_q[EN_REFDIV] &&
      (refpath_q[REF_AUTO_SEL] ? refpath_q[REF_RATIO_MSB:0] != 14'h0001
                               : refpath_q[REF_DIV_SEL]);
    // ratio passed through; keeping it legal is up to software
    ctrl_d.refdiv_ratio = refpath_q[REF_RATIO_MSB:0];
    // sine select passed out as written
    ctrl_d.sine_ref_sel = refpath_q[REF_SINE_SEL];
    ctrl_d.mod_clk_from_vco = enables_q[EN_MOD_CLK_SEL];
    ctrl_d.pump_enable = enables_q[EN_PUMP];
    ctrl_d.mod_run = enables_q[EN_MOD_RSTN];
    ctrl_d.lock_run = enables_q[EN_LOCK_RSTN];
    ctrl_d.lock_gate = enables_q[EN_LOCK_GATE];
    ctrl_d.slip_prevent_en = enables_q[EN_SLIP_RSTN];
    ctrl_d.presc_long_low = presc_q;
    ctrl_d.pfd_invert = pfd_q[PFD_POLARITY];
    ctrl_d.pfd_up_en = pfd_q[PFD_UP_EN];
    ctrl_d.pfd_dn_en = pfd_q[PFD_DN_EN];
    ctrl_d.pfd_delay = pfd_delay_q;
  end

  // decoded controls registered so every output is a flop; costs one clock of lag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ctrl <= '0;
    end else begin
      o_ctrl <= ctrl_d;
    end
  end

endmodule : synth_enable_refpath_pfd_regs

`default_nettype wire

// [verif/synth_regs_props.sv]
// checker: port timing relations of the synth control bank
`timescale 1ns/1ps
`default_nettype none
module synth_regs_props
  import synth_regs_pkg::*;
(
  // watched ports
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sen,
  input wire logic i_lock_status,
  input wire logic o_lock_or_serial_out_pin,
  input wire logic o_lock_or_serial_out_pin_oe,
  input wire logic o_digital_reset,
  input wire logic o_temp_clock,
  input wire synth_ctrl_t o_ctrl
);
  logic [3:0] quiet_q;
  // cycles since the frame enable was high; saturates so it never wraps
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quiet_q <= 4'h0;
    end else if (i_sen) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // port long idle, all sync stages settled
  sequence idle_s;
    quiet_q > 4'hC;
  endsequence
  a_temp_one_pulse: assert property (o_temp_clock |=> !o_temp_clock [*8])
    else $error("temp clock pulse too long");
  a_dig_one_pulse: assert property (o_digital_reset |=> !o_digital_reset [*8])
    else $error("digital reset pulse too long");
  a_temp_needs_frame: assert property (o_temp_clock |-> quiet_q < 4'hC)
    else $error("temp clock without a frame");
  a_dig_needs_frame: assert property (o_digital_reset |-> quiet_q < 4'hC)
    else $error("digital reset without a frame");
  a_ctrl_frame_only: assert property ($changed(o_ctrl) |-> quiet_q < 4'hC)
    else $error("controls moved while port idle");
  a_oe_frame_only: assert property ($changed(o_lock_or_serial_out_pin_oe) |-> quiet_q <= 4'hC)
    else $error("driver enable moved while port idle");
  a_pin_lock_high: assert property (idle_s ##0 $rose(i_lock_status) |->
    ##[1:6] o_lock_or_serial_out_pin) else $error("pin missed lock rise");
  a_pin_lock_low: assert property (idle_s ##0 $fell(i_lock_status) |->
    ##[1:6] !o_lock_or_serial_out_pin) else $error("pin missed lock fall");
endmodule : synth_regs_props
bind synth_enable_refpath_pfd_regs synth_regs_props i_props (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_sen(i_sen), .i_lock_status(i_lock_status),
  .o_lock_or_serial_out_pin(o_lock_or_serial_out_pin),
  .o_lock_or_serial_out_pin_oe(o_lock_or_serial_out_pin_oe),
  .o_digital_reset(o_digital_reset), .o_temp_clock(o_temp_clock), .o_ctrl(o_ctrl));
`default_nettype wire

// [verif/serial_host_model.sv]
// host model: four-wire serial master that paces frames off the system clock
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // pacing clock
  input wire logic i_clk,
  // serial pins
  output logic o_sclk,
  output logic o_sen,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  int half = 8; // sclk half period in clocks; slow host uses more
  logic last_q = 1'b0;
  // idle pins; sclk stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_sen = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [5:0] addr, input logic [23:0] wd,
                      output logic [23:0] rdat);
    logic [30:0] frame;
    frame = {rd, addr, wd};
    rdat = 24'h0;
    o_sen <= 1'b1;
    for (int b = 30; b >= 0; b--) begin
      o_sdi <= frame[b];
      repeat (half) @(negedge i_clk);
      o_sclk <= 1'b1;
      repeat (half) @(negedge i_clk);
      o_sclk <= 1'b0;
      // undriven pin reads as the inverse of the last bit, never a lucky match
      last_q = i_sdo_oe ? i_sdo : ~last_q;
      rdat[b % 24] = (b < 24) ? last_q : rdat[b % 24];
    end
    o_sen <= 1'b0;
    repeat (16) @(negedge i_clk);
  endtask : xfer
endmodule : serial_host_model
`default_nettype wire

// [verif/tb.sv]
// testbench: serial register traffic checked against an integer model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import synth_regs_pkg::*;
  localparam logic [23:0] ID_VAL = 24'h3C5A96; // arbitrary identification value
  localparam int MASK [8] = '{0, 'hFFFF, 3, 'h1FFFF, 1, 7, 7, 0};
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic sclk, sen, sdi, pin, oe, dig, temp;
  logic lock = 1'b0;
  logic [23:0] rd;
  synth_ctrl_t ctrl;
  int err_count = 0, checks = 0, tcnt = 0, dcnt = 0, a, d;
  int mdl [8];
  int stb [6] = '{0, 8, 2, 4, 'hA, 1};
  int refv [4] = '{'h08001, 'h08005, 'h04001, 'h00005};
  integer seed = 32'h20221774;

  synth_enable_refpath_pfd_regs #(.ID_WORD(ID_VAL)) i_dut (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_sclk(sclk), .i_sen(sen), .i_sdi(sdi), .i_lock_status(lock),
    .o_lock_or_serial_out_pin(pin), .o_lock_or_serial_out_pin_oe(oe),
    .o_digital_reset(dig), .o_temp_clock(temp), .o_ctrl(ctrl));
  serial_host_model i_host (.i_clk(i_clk), .o_sclk(sclk), .o_sen(sen), .o_sdi(sdi),
    .i_sdo(pin), .i_sdo_oe(oe));

  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  // count strobe pulses seen at the outputs
  always @(posedge i_clk) begin
    tcnt += (temp === 1'b1);
    dcnt += (dig === 1'b1);
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_ctrl(input synth_ctrl_t got, input synth_ctrl_t exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t controls %h expected %h", $time, got, exp);
    end
  endtask : cmp_ctrl

  // decoded levels from the model; divider runs only when enabled and picked
  function automatic synth_ctrl_t exp_ctrl();
    logic act;
    act = mdl[1][2] & (mdl[3][15] ? (mdl[3][13:0] != 1) : mdl[3][14]);
    return {mdl[1][1], act, mdl[3][13:0], mdl[3][16], mdl[1][9], mdl[1][12], mdl[1][13],
      mdl[1][14], mdl[1][11], mdl[1][15], mdl[4][0], mdl[5][0], mdl[5][1], mdl[5][2],
      mdl[6][2:0]};
  endfunction : exp_ctrl

  task automatic wr(input int ad, input int dv);
    i_host.xfer(1'b0, ad[5:0], dv[23:0], rd);
    if (ad > 0 && ad < 7) mdl[ad] = dv & MASK[ad];
  endtask : wr

  // addresses 0 through 7 read back, then idle pin state and controls
  task automatic check_all();
    for (int k = 0; k < 8; k++) begin
      i_host.xfer(1'b1, k[5:0], 24'h0, rd);
      cmp_val(rd, (k == 0) ? ID_VAL : mdl[k]);
    end
    cmp_val(oe, mdl[2][1] & mdl[2][0]);
    cmp_val(pin, lock);
    cmp_ctrl(ctrl, exp_ctrl());
  endtask : check_all

  task automatic final_report();
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // hang guard
  initial begin
    #2500000;
    err_count++;
    final_report();
  end

  // main sequence
  initial begin
    mdl = '{0, 'hFE9B, 3, 'h08001, 0, 6, 2, 0};
    repeat (10) @(negedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(negedge i_clk);
    check_all();
    for (int n = 0; n < 12; n++) begin
      a = 1 + (($random(seed) & 'h7FFF) % 7);
      d = $random(seed);
      if (a == 2) d = (d & 2) ? 3 : d & 1;
      // sine select follows the sine buffer enable
      if (a == 3) d[16] = mdl[1][8];
      // software never writes a zero ratio
      if (a == 3 && d[13:0] == 0) d[0] = 1;
      i_host.half = n[0] ? 12 : 8;
      lock <= d[5];
      wr(a, d);
      if (n % 4 == 3) check_all();
    end
    wr(1, mdl[1] | 4);
    foreach (refv[i]) begin
      wr(3, refv[i]);
      cmp_ctrl(ctrl, exp_ctrl());
    end
    wr(2, 2);
    cmp_val(oe, 0);
    wr(2, 0);
    check_all();
    foreach (stb[i]) begin
      tcnt = 0;
      dcnt = 0;
      wr(0, stb[i]);
      cmp_val(tcnt, stb[i][3]);
      cmp_val(dcnt, stb[i][1]);
      if (stb[i][0]) mdl = '{0, 'hFE9B, 3, 'h08001, 0, 6, 2, 0};
    end
    check_all();
    final_report();
  end
endmodule : tb
`default_nettype wire
